/* hdl/stac_ctrl.sv */
/*
  Switch table access controller: management registers for the VLAN table
  and the address lookup table, the action sequencer, and both tables.
  Assumes a synchronous byte-wide management port, one access per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - VLAN go bit starts action, self-clears
// - VLAN action nop, write, read at index
// - VLAN code 11 zeroes whole table
// - filter group id joins lookup hash
// - key high supplies MAC bits 47:32
// - key low supplies MAC bits 31:0
// - direct mode uses key low 11:0
// - direct bit picks direct or hashed
// - lookup action nop, write, read, search
// - lookup go bit self-clears when finished
// - entry-ready flag, cleared reading 0x042F
// - bit 5 is ready or search ended
// - valid entry count after search
// - VLAN index selects entry
// - four entry registers from 0x0420
module stac_ctrl (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid
);
    localparam int AW = stac_pkg::TABLE_AW;
    localparam logic [AW-1:0] LAST = AW'(stac_pkg::TABLE_DEPTH - 1);

    stac_pkg::stac_state_t state_q;
    logic [31:0] ve0_q, ve1_q, ve2_q, vic_q, kh_q, kl_q, lc_q;
    logic [31:0] ent_q [4];
    logic [AW-1:0] scan_q;
    logic [stac_pkg::COUNT_W-1:0] count_q;
    logic valid_q, srch_end_q;
    logic vlan_done, lkp_done, vlan_load, lkp_load, srch_hit;
    logic [1:0] vact, lact;
    logic direct;
    logic [AW-1:0] lkp_idx;
    logic vm_en, vm_we, am_en, am_we;
    logic [AW-1:0] vm_addr, am_addr;
    logic [95:0] vm_wdata, vm_rdata;
    logic [127:0] am_wdata, am_rdata;
    logic [31:0] rword;
    logic ack_rd;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] wreg(input logic [31:0] old,
        input logic hit, input logic [1:0] lane, input logic [7:0] d,
        input logic [31:0] mask);
        logic [31:0] m;
        m = old;
        m[lane*8 +: 8] = d;
        wreg = hit ? ((m & mask) | (old & ~mask)) : old;
    endfunction

    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        hit = (a[15:2] == off[15:2]);
    endfunction

    // xor fold of filter group and 48-bit MAC down to the table index
    function automatic logic [AW-1:0] hash(input logic [6:0] grp,
        input logic [47:0] mac);
        hash = {5'h00, grp} ^ mac[11:0] ^ mac[23:12] ^ mac[35:24]
            ^ mac[47:36];
    endfunction

    assign vact = vic_q[stac_pkg::VLAN_ACT_LSB +: 2];
    assign lact = lc_q[stac_pkg::LKP_ACT_LSB +: 2];
    assign direct = lc_q[stac_pkg::LKP_DIRECT_BIT];
    assign ack_rd = reg_rd && reg_addr == stac_pkg::OFF_SEARCH_ACK;

    // direct index skips the hash, meant for debug only
    assign lkp_idx = direct ? kl_q[AW-1:0]
        : hash(kh_q[stac_pkg::KEY_GROUP_LSB +: 7],
            {kh_q[stac_pkg::KEY_MAC_LSB +: 16], kl_q});

    // ------------------------------------------------------------
    // table port drive, decoded from the sequencer state
    // ------------------------------------------------------------
    always_comb
    begin
        vm_en = (state_q == stac_pkg::ST_VISS) || (state_q == stac_pkg::ST_VCLR);
        vm_we = (state_q == stac_pkg::ST_VCLR)
            || (state_q == stac_pkg::ST_VISS && vact == stac_pkg::ACT_WRITE);
        vm_addr = (state_q == stac_pkg::ST_VCLR) ? scan_q
            : vic_q[stac_pkg::VLAN_IDX_LSB +: AW];
        vm_wdata = (state_q == stac_pkg::ST_VCLR) ? 96'h0
            : {ve2_q, ve1_q, ve0_q};
        am_en = (state_q == stac_pkg::ST_AISS) || (state_q == stac_pkg::ST_SRD);
        am_we = state_q == stac_pkg::ST_AISS && lact == stac_pkg::ACT_WRITE;
        am_addr = (state_q == stac_pkg::ST_SRD) ? scan_q : lkp_idx;
        am_wdata = {ent_q[3], ent_q[2], ent_q[1], ent_q[0]};
    end

    stac_table_mem #(.WIDTH(96), .DEPTH(stac_pkg::TABLE_DEPTH), .AW(AW))
    u_vlan_mem (
        .core_clk(core_clk),
        .ce(ce),
        .en(vm_en),
        .we(vm_we),
        .addr(vm_addr),
        .wdata(vm_wdata),
        .rdata(vm_rdata)
    );

    stac_table_mem #(.WIDTH(128), .DEPTH(stac_pkg::TABLE_DEPTH), .AW(AW))
    u_lookup_mem (
        .core_clk(core_clk),
        .ce(ce),
        .en(am_en),
        .we(am_we),
        .addr(am_addr),
        .wdata(am_wdata),
        .rdata(am_rdata)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        vlan_done = 1'b0;
        lkp_done = 1'b0;
        vlan_load = state_q == stac_pkg::ST_VWAIT;
        lkp_load = state_q == stac_pkg::ST_AWAIT;
        srch_hit = state_q == stac_pkg::ST_SCHK
            && am_rdata[stac_pkg::ENT_VALID_BIT];
        case (state_q)
            stac_pkg::ST_IDLE:
            begin
                vlan_done = vic_q[stac_pkg::VLAN_GO_BIT]
                    && vact == stac_pkg::ACT_NOP;
                lkp_done = !vic_q[stac_pkg::VLAN_GO_BIT]
                    && lc_q[stac_pkg::LKP_GO_BIT] && lact == stac_pkg::ACT_NOP;
            end
            stac_pkg::ST_VISS: vlan_done = vact != stac_pkg::ACT_READ;
            stac_pkg::ST_VWAIT: vlan_done = 1'b1;
            stac_pkg::ST_VCLR: vlan_done = scan_q == LAST;
            stac_pkg::ST_AISS: lkp_done = lact != stac_pkg::ACT_READ;
            stac_pkg::ST_AWAIT: lkp_done = 1'b1;
            stac_pkg::ST_SCHK: lkp_done = !srch_hit && scan_q == LAST;
            stac_pkg::ST_SHOLD: lkp_done = !valid_q && scan_q == LAST;
            default: ;
        endcase
    end

    // vlan table has priority when both go bits are set together
    always_ff @(posedge core_clk)
    begin
        if (rst)
            state_q <= stac_pkg::ST_IDLE;
        else if (ce)
            case (state_q)
                stac_pkg::ST_IDLE:
                    if (vic_q[stac_pkg::VLAN_GO_BIT])
                        case (vact)
                            stac_pkg::ACT_NOP: state_q <= stac_pkg::ST_IDLE;
                            stac_pkg::ACT_ALL: state_q <= stac_pkg::ST_VCLR;
                            default: state_q <= stac_pkg::ST_VISS;
                        endcase
                    else if (lc_q[stac_pkg::LKP_GO_BIT])
                        case (lact)
                            stac_pkg::ACT_NOP: state_q <= stac_pkg::ST_IDLE;
                            stac_pkg::ACT_ALL: state_q <= stac_pkg::ST_SRD;
                            default: state_q <= stac_pkg::ST_AISS;
                        endcase
                stac_pkg::ST_VISS:
                    state_q <= (vact == stac_pkg::ACT_READ)
                        ? stac_pkg::ST_VWAIT : stac_pkg::ST_IDLE;
                stac_pkg::ST_VCLR:
                    if (vlan_done)
                        state_q <= stac_pkg::ST_IDLE;
                stac_pkg::ST_AISS:
                    state_q <= (lact == stac_pkg::ACT_READ)
                        ? stac_pkg::ST_AWAIT : stac_pkg::ST_IDLE;
                stac_pkg::ST_SRD: state_q <= stac_pkg::ST_SCHK;
                stac_pkg::ST_SCHK:
                    state_q <= srch_hit ? stac_pkg::ST_SHOLD
                        : lkp_done ? stac_pkg::ST_IDLE : stac_pkg::ST_SRD;
                stac_pkg::ST_SHOLD:
                    if (!valid_q)
                        state_q <= lkp_done ? stac_pkg::ST_IDLE
                            : stac_pkg::ST_SRD;
                default: state_q <= stac_pkg::ST_IDLE;
            endcase
    end

    // scan position and valid count for clear-all and search
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            scan_q <= '0;
            count_q <= '0;
        end
        else if (ce)
        begin
            if (state_q == stac_pkg::ST_IDLE)
                scan_q <= '0;
            else if ((state_q == stac_pkg::ST_VCLR && !vlan_done)
                || (state_q == stac_pkg::ST_SCHK && !srch_hit && !lkp_done)
                || (state_q == stac_pkg::ST_SHOLD && !valid_q && !lkp_done))
                scan_q <= scan_q + 1'b1;
            if (state_q == stac_pkg::ST_IDLE && lc_q[stac_pkg::LKP_GO_BIT]
                && !vic_q[stac_pkg::VLAN_GO_BIT] && lact == stac_pkg::ACT_ALL)
                count_q <= '0;
            else if (srch_hit)
                count_q <= count_q + 1'b1;
        end
    end

    // search flags; a new hit wins over a same-cycle acknowledge
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            valid_q <= 1'b0;
            srch_end_q <= 1'b0;
        end
        else if (ce)
        begin
            if (srch_hit)
                valid_q <= 1'b1;
            else if (ack_rd)
                valid_q <= 1'b0;
            if (lkp_done && lact == stac_pkg::ACT_ALL)
                srch_end_q <= 1'b1;
            else if (state_q == stac_pkg::ST_SRD && scan_q == '0)
                srch_end_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register writes; go bits only set by host, cleared by hardware
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ve0_q <= stac_pkg::RST_WORD;
            ve1_q <= stac_pkg::RST_WORD;
            ve2_q <= stac_pkg::RST_WORD;
            vic_q <= stac_pkg::RST_WORD;
            kh_q <= stac_pkg::RST_WORD;
            kl_q <= stac_pkg::RST_WORD;
            lc_q <= stac_pkg::RST_WORD;
        end
        else if (ce)
        begin
            if (vlan_load)
            begin
                ve0_q <= vm_rdata[31:0] & stac_pkg::WM_VLAN_ENTRY0;
                ve1_q <= vm_rdata[63:32] & stac_pkg::WM_VLAN_ENTRY12;
                ve2_q <= vm_rdata[95:64] & stac_pkg::WM_VLAN_ENTRY12;
            end
            else
            begin
                ve0_q <= wreg(ve0_q, reg_wr && hit(reg_addr,
                    stac_pkg::OFF_VLAN_ENTRY0), reg_addr[1:0], reg_wdata,
                    stac_pkg::WM_VLAN_ENTRY0);
                ve1_q <= wreg(ve1_q, reg_wr && hit(reg_addr,
                    stac_pkg::OFF_VLAN_ENTRY1), reg_addr[1:0], reg_wdata,
                    stac_pkg::WM_VLAN_ENTRY12);
                ve2_q <= wreg(ve2_q, reg_wr && hit(reg_addr,
                    stac_pkg::OFF_VLAN_ENTRY2), reg_addr[1:0], reg_wdata,
                    stac_pkg::WM_VLAN_ENTRY12);
            end
            vic_q <= wreg(vic_q & ~(32'(vlan_done) << stac_pkg::VLAN_GO_BIT),
                reg_wr && hit(reg_addr, stac_pkg::OFF_VLAN_INDEX),
                reg_addr[1:0], reg_wdata, stac_pkg::WM_VLAN_IDX_CTRL)
                | (vic_q & ~(32'(vlan_done) << stac_pkg::VLAN_GO_BIT)
                & (32'h1 << stac_pkg::VLAN_GO_BIT));
            kh_q <= wreg(kh_q, reg_wr && hit(reg_addr, stac_pkg::OFF_KEY_HIGH),
                reg_addr[1:0], reg_wdata, stac_pkg::WM_KEY_HIGH);
            kl_q <= wreg(kl_q, reg_wr && hit(reg_addr, stac_pkg::OFF_KEY_LOW),
                reg_addr[1:0], reg_wdata, stac_pkg::WM_KEY_LOW);
            lc_q <= wreg(lc_q & ~(32'(lkp_done) << stac_pkg::LKP_GO_BIT),
                reg_wr && hit(reg_addr, stac_pkg::OFF_LOOKUP_CTRL),
                reg_addr[1:0], reg_wdata, stac_pkg::WM_LOOKUP_CTRL)
                | (lc_q & ~(32'(lkp_done) << stac_pkg::LKP_GO_BIT)
                & (32'h1 << stac_pkg::LKP_GO_BIT));
        end
    end

    // lookup entry registers, loaded by read and by search hits
    always_ff @(posedge core_clk)
    begin
        if (rst)
            for (int i = 0; i < 4; i++)
                ent_q[i] <= stac_pkg::RST_WORD;
        else if (ce)
            for (int i = 0; i < 4; i++)
                if (lkp_load || srch_hit)
                    ent_q[i] <= am_rdata[i*32 +: 32];
                else
                    ent_q[i] <= wreg(ent_q[i], reg_wr && reg_addr[15:4]
                        == stac_pkg::OFF_ENTRY0[15:4] && reg_addr[3:2]
                        == 2'(i), reg_addr[1:0], reg_wdata, 32'hffffffff);
    end

    // ------------------------------------------------------------
    // read path, one cycle of latency, unmapped bytes read zero
    // ------------------------------------------------------------
    always_comb
    begin
        rword = 32'h0;
        case ({reg_addr[15:2], 2'h0})
            stac_pkg::OFF_VLAN_ENTRY0: rword = ve0_q;
            stac_pkg::OFF_VLAN_ENTRY1: rword = ve1_q;
            stac_pkg::OFF_VLAN_ENTRY2: rword = ve2_q;
            stac_pkg::OFF_VLAN_INDEX: rword = vic_q;
            stac_pkg::OFF_KEY_HIGH: rword = kh_q;
            stac_pkg::OFF_KEY_LOW: rword = kl_q;
            stac_pkg::OFF_LOOKUP_CTRL:
                rword = lc_q | (32'(count_q) << stac_pkg::LKP_COUNT_LSB)
                    | (32'(valid_q) << stac_pkg::LKP_VALID_BIT)
                    | (32'(valid_q | srch_end_q)
                    << stac_pkg::LKP_EITHER_BIT);
            stac_pkg::OFF_ENTRY0: rword = ent_q[0];
            stac_pkg::OFF_ENTRY1: rword = ent_q[1];
            stac_pkg::OFF_ENTRY2: rword = ent_q[2];
            stac_pkg::OFF_ENTRY3: rword = ent_q[3];
            default: rword = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else if (ce)
        begin
            reg_rdata <= reg_rd ? rword[reg_addr[1:0]*8 +: 8] : 8'h00;
            reg_rvalid <= reg_rd;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst || !ce);

    sequence s_clr_last;
        state_q == stac_pkg::ST_VCLR && scan_q == LAST;
    endsequence

    chk_vlan_rd_load: assert property (
        state_q == stac_pkg::ST_VWAIT |=> ve0_q == ($past(vm_rdata[31:0])
            & stac_pkg::WM_VLAN_ENTRY0) && !vic_q[stac_pkg::VLAN_GO_BIT])
        else $error("vlan read did not load staging");
    chk_vlan_clr_zero: assert property (
        state_q == stac_pkg::ST_VCLR |-> vm_we && vm_wdata == 96'h0)
        else $error("clear-all wrote nonzero");
    chk_clr_scan_step: assert property (
        state_q == stac_pkg::ST_VCLR && scan_q != LAST
            |=> state_q == stac_pkg::ST_VCLR
            && scan_q == $past(scan_q) + 1'b1)
        else $error("clear-all skipped an entry");
    chk_vlan_clr_end: assert property (
        s_clr_last |=> state_q == stac_pkg::ST_IDLE
            && !vic_q[stac_pkg::VLAN_GO_BIT])
        else $error("clear-all did not finish");
    chk_hash_index: assert property (
        state_q == stac_pkg::ST_AISS && !direct |-> am_addr == hash(
            kh_q[22:16], {kh_q[15:0], kl_q}))
        else $error("hashed index wrong");
    chk_direct_index: assert property (
        state_q == stac_pkg::ST_AISS && direct |-> am_addr == kl_q[11:0])
        else $error("direct index wrong");
    chk_valid_ack: assert property (
        valid_q && ack_rd && !srch_hit |=> !valid_q)
        else $error("entry-ready flag not cleared");
    chk_resume_scan: assert property (
        state_q == stac_pkg::ST_SHOLD && !valid_q && scan_q != LAST
            |=> state_q == stac_pkg::ST_SRD ##1 state_q == stac_pkg::ST_SCHK)
        else $error("search did not resume");
    chk_search_end: assert property (
        state_q == stac_pkg::ST_SCHK && !srch_hit && scan_q == LAST
            |=> !lc_q[stac_pkg::LKP_GO_BIT] && srch_end_q)
        else $error("search end not reported");
    chk_count_step: assert property (
        srch_hit |=> count_q == $past(count_q) + 1'b1)
        else $error("valid count did not advance");
endmodule
`default_nettype wire

/* hdl/stac_pkg.sv */
/*
  Shared constants for the switch table access controller: byte offsets of
  the management registers, field positions, write masks, action codes and
  the controller state type.
  Assumes a byte-wide management port that addresses bytes directly.
*/
package stac_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [15:0] OFF_VLAN_ENTRY0 = 16'h0400;
    localparam logic [15:0] OFF_VLAN_ENTRY1 = 16'h0404;
    localparam logic [15:0] OFF_VLAN_ENTRY2 = 16'h0408;
    localparam logic [15:0] OFF_VLAN_INDEX = 16'h040c;
    localparam logic [15:0] OFF_VLAN_OP_CTRL = 16'h040e;
    localparam logic [15:0] OFF_KEY_HIGH = 16'h0410;
    localparam logic [15:0] OFF_KEY_LOW = 16'h0414;
    localparam logic [15:0] OFF_LOOKUP_CTRL = 16'h0418;
    localparam logic [15:0] OFF_ENTRY0 = 16'h0420;
    localparam logic [15:0] OFF_ENTRY1 = 16'h0424;
    localparam logic [15:0] OFF_ENTRY2 = 16'h0428;
    localparam logic [15:0] OFF_ENTRY3 = 16'h042c;
    localparam logic [15:0] OFF_SEARCH_ACK = 16'h042f;
    // ------------------------------------------------------------
    // field positions within the 32-bit word images
    // ------------------------------------------------------------
    localparam int VLAN_GO_BIT = 23;
    localparam int VLAN_ACT_LSB = 16;
    localparam int VLAN_IDX_LSB = 0;
    localparam int KEY_GROUP_LSB = 16;
    localparam int KEY_MAC_LSB = 0;
    localparam int LKP_GO_BIT = 7;
    localparam int LKP_VALID_BIT = 6;
    localparam int LKP_EITHER_BIT = 5;
    localparam int LKP_DIRECT_BIT = 2;
    localparam int LKP_ACT_LSB = 0;
    localparam int LKP_COUNT_LSB = 16;
    localparam int ENT_VALID_BIT = 31;
    // ------------------------------------------------------------
    // writable bits of each word; others read as zero, except the lookup control status bits and count
    // ------------------------------------------------------------
    localparam logic [31:0] WM_VLAN_ENTRY0 = 32'h8f00707f;
    localparam logic [31:0] WM_VLAN_ENTRY12 = 32'h00000007;
    localparam logic [31:0] WM_VLAN_IDX_CTRL = 32'h00830fff;
    localparam logic [31:0] WM_KEY_HIGH = 32'h807fffff;
    localparam logic [31:0] WM_KEY_LOW = 32'hffffffff;
    localparam logic [31:0] WM_LOOKUP_CTRL = 32'h0000009f;
    localparam logic [31:0] RST_WORD = 32'h00000000;
    // ------------------------------------------------------------
    // action codes, shared by both tables
    // ------------------------------------------------------------
    localparam logic [1:0] ACT_NOP = 2'h0;
    localparam logic [1:0] ACT_WRITE = 2'h1;
    localparam logic [1:0] ACT_READ = 2'h2;
    localparam logic [1:0] ACT_ALL = 2'h3;
    localparam int TABLE_DEPTH = 4096;
    localparam int TABLE_AW = 12;
    localparam int COUNT_W = 14;

    typedef enum logic [3:0] {
        ST_IDLE, ST_VISS, ST_VWAIT, ST_VCLR,
        ST_AISS, ST_AWAIT, ST_SRD, ST_SCHK, ST_SHOLD
    } stac_state_t;
endpackage

/* hdl/stac_table_mem.sv */
/*
  Single-port table memory with registered read data.
  Assumes one access per cycle; read data appear one cycle after the request.
*/
`timescale 1ns/1ps
`default_nettype none
module stac_table_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4096,
    parameter int AW = 12
) (
    input wire logic core_clk,
    input wire logic ce,
    input wire logic en,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    if (DEPTH > (1 << AW)) begin : g_chk
        $error("table depth exceeds address range");
    end

    // write-first is not needed: reads and writes never share a cycle
    always_ff @(posedge core_clk)
    begin
        if (ce && en)
        begin
            if (we)
                mem[addr] <= wdata;
            rdata <= mem[addr];
        end
    end
endmodule
`default_nettype wire

/* tb/stac_host_model.sv */
/*
  Host model: byte-wide register port master for the table controller.
  Assumes the bench clock; strobes change 1 ns after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module stac_host_model (
    input wire logic core_clk,
    output logic [15:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    // ----------------------------------------------
    // byte cycles, one idle edge between strobes
    // ----------------------------------------------
    initial
    begin
        reg_addr = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // released lines show the inverse, so stale values never match
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge core_clk) #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge core_clk) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge core_clk) #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
    endtask
    task automatic wr32(input logic [15:0] a, input logic [31:0] v);
        for (int i = 0; i < 4; i++)
            wr(a + 16'(i), v[8*i +: 8]);
    endtask
    task automatic rd32(input logic [15:0] a, output logic [31:0] v);
        logic [7:0] b;
        for (int i = 0; i < 4; i++)
        begin
            rd(a + 16'(i), b);
            v[8*i +: 8] = b;
        end
    endtask
    // polls a byte until bit k equals v; the bench watchdog bounds a hang
    task automatic wait_bit(input logic [15:0] a, input int k,
        input logic v, output logic [7:0] d);
        do
            rd(a, d);
        while (d[k] !== v);
    endtask
    // launch, then never touch the table until go reads zero
    task automatic go(input logic [15:0] a, input logic [7:0] c,
        output logic [7:0] d);
        wr(a, c);
        wait_bit(a, 7, 1'b0, d);
    endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
/*
  Self-checking bench for the table controller: register sequences.
  Assumes the host model drives the register port; ce held high except during one write.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk, rst, ce, reg_wr, reg_rd, reg_rvalid;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, b;
    logic [31:0] w;
    int err_total = 0;
    int checks_done = 0;
    stac_ctrl dut_u (.core_clk(core_clk), .rst(rst), .ce(ce),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));
    stac_host_model host_u (.core_clk(core_clk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    // ----------------------------------------------
    // clock, compare, verdict, watchdog
    // ----------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("mismatches %0d of %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // about 55k cycles expected; cut off well past that
    initial
    begin
        #8000000;
        err_total++;
        stop_test();
    end
    // ----------------------------------------------
    // test sequence
    // ----------------------------------------------
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        repeat (5) @(posedge core_clk);
        #1 rst = 1'b0;
        host_u.rd32(16'h0414, w);
        chk(w, 32'h00000000);
        // a write while the clock enable is low must not land
        ce = 1'b0;
        host_u.wr(16'h0414, 8'h5a);
        ce = 1'b1;
        host_u.rd(16'h0414, b);
        chk(32'(b), 32'h00);
        host_u.rd32(16'h0418, w);
        chk(w, 32'h00000000);
        // vlan write at index 5, wipe staging, read back masked
        host_u.wr32(16'h0400, 32'hffffffff);
        host_u.wr(16'h040c, 8'h05);
        host_u.go(16'h040e, 8'h81, b);
        chk(32'(b), 32'h01);
        host_u.wr32(16'h0400, 32'h0);
        host_u.go(16'h040e, 8'h82, b);
        host_u.rd32(16'h0400, w);
        chk(w, 32'h8f00707f);
        // clear-all with another index loaded; go stands meanwhile
        host_u.wr(16'h040c, 8'h09);
        host_u.wr(16'h040e, 8'h83);
        host_u.rd(16'h040e, b);
        chk(32'(b), 32'h83);
        host_u.wait_bit(16'h040e, 7, 1'b0, b);
        host_u.wr(16'h040c, 8'h05);
        // no-op must neither load staging nor touch the table
        host_u.go(16'h040e, 8'h80, b);
        chk(32'(b), 32'h00);
        host_u.rd32(16'h0400, w);
        chk(w, 32'h8f00707f);
        host_u.go(16'h040e, 8'h82, b);
        host_u.rd32(16'h0400, w);
        chk(w, 32'h0);
        // lookup memory is not reset: empty every slot first
        for (int s = 0; s < 4096; s++)
        begin
            host_u.wr(16'h0414, 8'(s));
            host_u.wr(16'h0415, 8'(s >> 8));
            host_u.go(16'h0418, 8'h85, b);
        end
        host_u.go(16'h0418, 8'h80, b);
        chk(32'(b), 32'h00);
        host_u.wr32(16'h0420, 32'h80000001);
        host_u.wr32(16'h0414, 32'h7);
        host_u.go(16'h0418, 8'h85, b);
        chk(32'(b), 32'h05);
        // hashed: group 04, mac 1230_00000050 folds to slot 177
        host_u.wr32(16'h0410, 32'h00041230);
        host_u.wr32(16'h0414, 32'h00000050);
        host_u.wr32(16'h0420, 32'h80000002);
        host_u.go(16'h0418, 8'h81, b);
        host_u.wr32(16'h0420, 32'h0);
        host_u.wr32(16'h0414, 32'h177);
        host_u.go(16'h0418, 8'h86, b);
        host_u.rd32(16'h0420, w);
        chk(w, 32'h80000002);
        // search: two hits in slot order, each acked at 0x042f
        host_u.wr(16'h0418, 8'h83);
        for (int h = 1; h <= 2; h++)
        begin
            host_u.wait_bit(16'h0418, 5, 1'b1, b);
            chk(32'(b), 32'he3);
            host_u.rd32(16'h0420, w);
            chk(w, 32'h80000000 | 32'(h));
            host_u.rd(16'h042f, b);
        end
        host_u.wait_bit(16'h0418, 5, 1'b1, b);
        chk(32'(b), 32'h23);
        host_u.rd32(16'h0418, w);
        chk(w, 32'h00020023);
        stop_test();
    end
endmodule
`default_nettype wire
